// [pin_mux_pkg.sv]
/*
 * Shared constants for the pin function mux: register indices,
 * reset defaults, pin class masks and mux codes.
 * Assumes five ports of eight pins, pin index = port * 8 + bit.
 */
`default_nettype none
package pin_mux_pkg;
    localparam int NPORTS = 5;
    localparam int NPINS = 40;
    localparam int ADR_W = 9;
    localparam logic [2:0] NPORTS_3 = 3'h5;
    // register index inside a port window, byte address = index * 4
    localparam logic [3:0] REG_PORT_DATA = 4'h0;
    localparam logic [3:0] REG_DIRECTION = 4'h1;
    localparam logic [3:0] REG_ALT_SEL = 4'h2;
    localparam logic [3:0] REG_DIG_EN = 4'h3;
    localparam logic [3:0] REG_ANA_SEL = 4'h4;
    localparam logic [3:0] REG_PULL_DN = 4'h5;
    localparam logic [3:0] REG_PULL_UP = 4'h6;
    localparam logic [3:0] REG_FUNC_CTL = 4'h7;
    localparam logic [3:0] REG_LOCK = 4'h8;
    localparam logic [3:0] REG_COMMIT = 4'h9;
    // port window stride is 16 words
    localparam int PORT_SHIFT = 6;
    localparam logic [3:0] MUX_CODE_ALT = 4'h1;
    localparam logic [3:0] MUX_CODE_DEBUG = 4'h3;
    localparam logic [39:0] ALT_SEL_RST = 40'h00_00_0F_0C_3F;
    localparam logic [39:0] DIG_EN_RST = 40'h00_00_0F_0C_3F;
    localparam logic [39:0] PULL_UP_RST = 40'h00_00_0F_00_00;
    localparam logic [39:0] PULL_DN_RST = 40'h00_00_00_00_00;
    localparam logic [159:0] FUNC_CTL_RST = {
        32'h0000_0000,
        32'h0000_0000,
        {16'h0000, {4{MUX_CODE_DEBUG}}},
        {16'h0000, {2{MUX_CODE_ALT}}, 8'h00},
        {8'h00, {6{MUX_CODE_ALT}}}
    };
    // pins reached through the analog isolation circuit
    localparam logic [39:0] ISO_ANALOG_MASK = 40'h0F_0C_00_00_00;
    // pins wired straight to comparator and usb sense
    localparam logic [39:0] DIRECT_ANALOG_MASK = 40'h00_00_00_53_00;
    // pins guarded by the lock and commit registers
    localparam logic [39:0] PROTECT_MASK = 40'h00_00_0F_80_00;
    localparam logic [7:0] LOCKED_READ = 8'h01;
endpackage : pin_mux_pkg
`default_nettype wire

// [gpio_pin_function_mux.sv]
/*
 * Pin function mux for five eight-pin ports behind a classic
 * Wishbone slave. Assumes peripherals give per-pin drive and enable
 * and that pin inputs are synchronous to clk_i.
 */
// Local design decisions: the Wishbone slave port and the placing of the registers.
// Contract
// - isolated analog pins connect only when digital off and analog selected.
// - direct analog pins connect whenever the digital enable is clear.
// - peripheral owns a pin only with alternate select and digital enable set.
// - each pin's mux settings are independent of every other pin.
// - reset leaves pins tri-stated, analog selects zero, alternate selects and codes at defaults.
// - reset returns function, enable and pull settings to defaults.
// - serial and I2C pins default code one; debug pins code three, pull-up.
// - alternate select gives pin to peripheral, else data register drives.
// - protected pin alternate select, enable and pull-up writes need unlocked lock and set commit bits.
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_function_mux #(
    parameter logic [31:0] UNLOCK_KEY = 32'h0000_C0DE // value arbitrary
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [pin_mux_pkg::ADR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic [39:0] pin_i,
    output logic [39:0] pin_o,
    output logic [39:0] pin_oe_o,
    input wire logic [39:0] periph_do_i,
    input wire logic [39:0] periph_oe_i,
    output logic [39:0] periph_di_o,
    output logic [39:0] alt_active_o,
    output logic [159:0] pin_mux_code_o,
    output logic [39:0] pull_up_o,
    output logic [39:0] pull_down_o,
    output logic [39:0] analog_connect_o
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [39:0] alt_function_select;
        logic [39:0] digital_enable_bits;
        logic [39:0] analog_mode_select;
        logic [39:0] pull_down_select;
        logic [39:0] pull_up_select;
        logic [39:0] port_data;
        logic [39:0] direction;
        logic [39:0] config_commit;
        logic [39:0] pin_out;
        logic [39:0] pin_oe;
        logic [39:0] periph_in;
        logic [159:0] port_function_control;
        logic [4:0] config_lock;
        logic ack;
        logic [31:0] rdat;
    } state_t;

    localparam state_t RST_STATE = '{
        alt_function_select: pin_mux_pkg::ALT_SEL_RST,
        digital_enable_bits: pin_mux_pkg::DIG_EN_RST,
        analog_mode_select: '0,
        pull_down_select: pin_mux_pkg::PULL_DN_RST,
        pull_up_select: pin_mux_pkg::PULL_UP_RST,
        port_data: '0,
        direction: '0,
        config_commit: '0,
        pin_out: '0,
        pin_oe: '0,
        periph_in: '0,
        port_function_control: pin_mux_pkg::FUNC_CTL_RST,
        config_lock: '1,
        ack: 1'b0,
        rdat: '0
    };

    state_t state_reg;
    state_t state_next;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic hit;
    logic [2:0] port;
    logic [3:0] ridx;
    logic port_ok;
    logic [31:0] bmask;
    logic do_write;

    assign hit = cyc_i & stb_i & ~state_reg.ack;
    assign port = adr_i[pin_mux_pkg::ADR_W-1:pin_mux_pkg::PORT_SHIFT];
    assign ridx = adr_i[pin_mux_pkg::PORT_SHIFT-1:2];
    assign port_ok = port < pin_mux_pkg::NPORTS_3;
    assign bmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
    assign do_write = hit & we_i & port_ok;

    // merge byte lanes into an eight-bit port register
    function automatic logic [7:0] merge8(
        input logic [7:0] old,
        input logic [7:0] wd,
        input logic [7:0] bm
    );
        merge8 = (old & ~bm) | (wd & bm);
    endfunction : merge8

    // bits a write may change: open bits, or committed protected ones while the port is unlocked
    function automatic logic [7:0] commit_ok(
        input logic [7:0] prot,
        input logic unlocked,
        input logic [7:0] commit
    );
        commit_ok = ~prot | ({8{unlocked}} & commit);
    endfunction : commit_ok

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        int b;
        logic [7:0] ok;
        logic [7:0] bm8;
        logic [7:0] wd8;
        b = 0;
        ok = '0;
        bm8 = '0;
        wd8 = '0;
        state_next = state_reg;
        state_next.ack = hit;
        state_next.rdat = '0;
        if (port_ok) begin
            b = 8 * int'(port);
        end
        bm8 = bmask[7:0];
        wd8 = dat_i[7:0];
        ok = commit_ok(pin_mux_pkg::PROTECT_MASK[b+:8], ~state_reg.config_lock[port],
            state_reg.config_commit[b+:8]);
        if (hit && port_ok && !we_i) begin
            case (ridx)
                pin_mux_pkg::REG_PORT_DATA: state_next.rdat[7:0] = state_reg.port_data[b+:8];
                pin_mux_pkg::REG_DIRECTION: state_next.rdat[7:0] = state_reg.direction[b+:8];
                pin_mux_pkg::REG_ALT_SEL:
                    state_next.rdat[7:0] = state_reg.alt_function_select[b+:8];
                pin_mux_pkg::REG_DIG_EN:
                    state_next.rdat[7:0] = state_reg.digital_enable_bits[b+:8];
                pin_mux_pkg::REG_ANA_SEL:
                    state_next.rdat[7:0] = state_reg.analog_mode_select[b+:8];
                pin_mux_pkg::REG_PULL_DN:
                    state_next.rdat[7:0] = state_reg.pull_down_select[b+:8];
                pin_mux_pkg::REG_PULL_UP:
                    state_next.rdat[7:0] = state_reg.pull_up_select[b+:8];
                pin_mux_pkg::REG_FUNC_CTL:
                    state_next.rdat = state_reg.port_function_control[4*b+:32];
                pin_mux_pkg::REG_LOCK:
                    state_next.rdat[7:0] = state_reg.config_lock[port] ?
                        pin_mux_pkg::LOCKED_READ : 8'h00;
                pin_mux_pkg::REG_COMMIT: state_next.rdat[7:0] = state_reg.config_commit[b+:8];
                default: state_next.rdat = '0;
            endcase
        end
        if (do_write) begin
            case (ridx)
                pin_mux_pkg::REG_PORT_DATA:
                    state_next.port_data[b+:8] = merge8(state_reg.port_data[b+:8], wd8, bm8);
                pin_mux_pkg::REG_DIRECTION:
                    state_next.direction[b+:8] = merge8(state_reg.direction[b+:8], wd8, bm8);
                pin_mux_pkg::REG_ALT_SEL:
                    state_next.alt_function_select[b+:8] =
                        merge8(state_reg.alt_function_select[b+:8], wd8, bm8 & ok);
                pin_mux_pkg::REG_DIG_EN:
                    state_next.digital_enable_bits[b+:8] =
                        merge8(state_reg.digital_enable_bits[b+:8], wd8, bm8 & ok);
                pin_mux_pkg::REG_ANA_SEL:
                    state_next.analog_mode_select[b+:8] =
                        merge8(state_reg.analog_mode_select[b+:8], wd8, bm8);
                pin_mux_pkg::REG_PULL_DN:
                    state_next.pull_down_select[b+:8] =
                        merge8(state_reg.pull_down_select[b+:8], wd8, bm8);
                pin_mux_pkg::REG_PULL_UP:
                    state_next.pull_up_select[b+:8] =
                        merge8(state_reg.pull_up_select[b+:8], wd8, bm8 & ok);
                pin_mux_pkg::REG_FUNC_CTL:
                    state_next.port_function_control[4*b+:32] =
                        (state_reg.port_function_control[4*b+:32] & ~bmask) | (dat_i & bmask);
                pin_mux_pkg::REG_LOCK:
                    state_next.config_lock[port] = (dat_i != UNLOCK_KEY);
                pin_mux_pkg::REG_COMMIT:
                    if (!state_reg.config_lock[port]) begin
                        state_next.config_commit[b+:8] =
                            merge8(state_reg.config_commit[b+:8], wd8, bm8);
                    end
                default: state_next.ack = hit;
            endcase
        end
        for (int i = 0; i < pin_mux_pkg::NPINS; i++) begin
            if (state_reg.alt_function_select[i]) begin
                state_next.pin_out[i] = periph_do_i[i];
                state_next.pin_oe[i] = state_reg.digital_enable_bits[i] & periph_oe_i[i];
            end else begin
                state_next.pin_out[i] = state_reg.port_data[i];
                state_next.pin_oe[i] = state_reg.digital_enable_bits[i] & state_reg.direction[i];
                // digitally enabled input pins capture the pad level, overriding writes
                if (!state_reg.direction[i] && state_reg.digital_enable_bits[i]) begin
                    state_next.port_data[i] = pin_i[i];
                end
            end
            state_next.periph_in[i] = pin_i[i] & state_reg.alt_function_select[i] &
                state_reg.digital_enable_bits[i];
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= RST_STATE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign dat_o = state_reg.rdat;
    assign ack_o = state_reg.ack;
    assign pin_o = state_reg.pin_out;
    assign pin_oe_o = state_reg.pin_oe;
    assign periph_di_o = state_reg.periph_in;
    assign alt_active_o = state_reg.alt_function_select & state_reg.digital_enable_bits;
    assign pin_mux_code_o = state_reg.port_function_control;
    assign pull_up_o = state_reg.pull_up_select;
    assign pull_down_o = state_reg.pull_down_select;
    assign analog_connect_o =
        (pin_mux_pkg::ISO_ANALOG_MASK & ~state_reg.digital_enable_bits &
            state_reg.analog_mode_select) |
        (pin_mux_pkg::DIRECT_ANALOG_MASK & ~state_reg.digital_enable_bits);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_iso_analog;
        @(posedge clk_i) disable iff (rst_i)
        (analog_connect_o[26] == (!state_reg.digital_enable_bits[26] &&
            state_reg.analog_mode_select[26])) && !analog_connect_o[0];
    endproperty
    a_iso_analog: assert property (p_iso_analog)
        else $error("isolated analog connect wrong");

    property p_direct_analog;
        @(posedge clk_i) disable iff (rst_i)
        analog_connect_o[8] == !state_reg.digital_enable_bits[8];
    endproperty
    a_direct_analog: assert property (p_direct_analog)
        else $error("direct analog connect wrong");

    property p_periph_in;
        @(posedge clk_i) disable iff (rst_i)
        ##1 (periph_di_o & ~$past(alt_active_o)) == 40'h00_0000_0000;
    endproperty
    a_periph_in: assert property (p_periph_in)
        else $error("peripheral sees pin while not owner");

    property p_independent;
        @(posedge clk_i) disable iff (rst_i)
        (do_write && ridx == pin_mux_pkg::REG_FUNC_CTL && port == 3'h0) |=>
            $stable(state_reg.port_function_control[159:32]);
    endproperty
    a_independent: assert property (p_independent)
        else $error("code write leaked into another port");

    property p_reset_sel;
        @(posedge clk_i) disable iff (rst_i)
        $fell(rst_i) |-> state_reg.alt_function_select == pin_mux_pkg::ALT_SEL_RST &&
            pin_oe_o == '0 && state_reg.analog_mode_select == '0;
    endproperty
    a_reset_sel: assert property (p_reset_sel)
        else $error("reset select defaults wrong");

    property p_reset_pull;
        @(posedge clk_i) disable iff (rst_i)
        $fell(rst_i) |-> pull_up_o == pin_mux_pkg::PULL_UP_RST && pull_down_o == '0 &&
            state_reg.digital_enable_bits == pin_mux_pkg::DIG_EN_RST;
    endproperty
    a_reset_pull: assert property (p_reset_pull)
        else $error("reset pull or enable defaults wrong");

    property p_reset_code;
        @(posedge clk_i) disable iff (rst_i)
        $fell(rst_i) |-> pin_mux_code_o[3:0] == 4'h1 && pin_mux_code_o[67:64] == 4'h3 &&
            pin_mux_code_o[27:24] == 4'h0;
    endproperty
    a_reset_code: assert property (p_reset_code)
        else $error("reset mux codes wrong");

    property p_drive;
        @(posedge clk_i) disable iff (rst_i)
        ##1 pin_o[5] == ($past(state_reg.alt_function_select[5]) ?
            $past(periph_do_i[5]) : $past(state_reg.port_data[5]));
    endproperty
    a_drive: assert property (p_drive)
        else $error("pin drive source wrong");

    property p_protect;
        @(posedge clk_i) disable iff (rst_i)
        (do_write && port == 3'h1 && ridx == pin_mux_pkg::REG_ALT_SEL &&
            state_reg.config_lock[1]) |=> $stable(state_reg.alt_function_select[15]);
    endproperty
    a_protect: assert property (p_protect)
        else $error("locked protected pin changed");

    property p_code_field;
        @(posedge clk_i) disable iff (rst_i)
        (do_write && ridx == pin_mux_pkg::REG_FUNC_CTL && port == 3'h2 && sel_i == 4'hF) |=>
            pin_mux_code_o[95:64] == $past(dat_i);
    endproperty
    a_code_field: assert property (p_code_field)
        else $error("code fields not written");
endmodule : gpio_pin_function_mux
`default_nettype wire

// [pin_mux_end.sv]
`default_nettype none
`default_nettype wire

// [periph_model.sv]
/*
 * Far-side model: on-chip peripherals driving every pin with a
 * pattern that changes each cycle, and the pad wire level.
 * Assumes the bench supplies the level of undriven external pads.
 */
`timescale 1ns/1ps
`default_nettype none
module periph_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [39:0] pad_o_i,
    input wire logic [39:0] pad_oe_i,
    input wire logic [39:0] ext_i,
    output logic [39:0] pin_lvl_o,
    output logic [39:0] do_o,
    output logic [39:0] oe_o
);
    logic [7:0] cnt_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= 8'h00;
        end else begin
            cnt_reg <= cnt_reg + 8'h35;
        end
    end

    // peripherals always want the pad, value moves every cycle
    assign do_o = {5{cnt_reg}};
    assign oe_o = 40'hFF_FFFF_FFFF;
    // wire level: block drive wins, else the outside world
    assign pin_lvl_o = (pad_oe_i & pad_o_i) | (~pad_oe_i & ext_i);
endmodule : periph_model
`default_nettype wire

// [gpio_pin_function_mux_bench.sv]
/*
 * Self-checking bench for the pin function mux: reset defaults,
 * digital and analog routing, protected pins, unmapped addresses.
 * Assumes the one-cycle Wishbone answer of the design.
 */
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_function_mux_bench;
    localparam logic [31:0] KEY = 32'h0000_5A5A; // value arbitrary
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [8:0] adr_i = 9'h000;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0000_0000;
    logic [31:0] dat_o;
    logic ack_o;
    logic [39:0] pin_i, pin_o, pin_oe_o, periph_do_i, periph_oe_i, periph_di_o;
    logic [39:0] alt_active_o, pull_up_o, pull_down_o, analog_connect_o;
    logic [39:0] ext_lvl = 40'hA5_5A_C3_3C_96;
    logic [159:0] pin_mux_code_o;
    int err_total = 0;
    int checks_done = 0;
    int cycles = 0;

    always #50 clk_i = ~clk_i;

    gpio_pin_function_mux #(.UNLOCK_KEY(KEY)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .pin_i(pin_i), .pin_o(pin_o),
        .pin_oe_o(pin_oe_o), .periph_do_i(periph_do_i), .periph_oe_i(periph_oe_i),
        .periph_di_o(periph_di_o), .alt_active_o(alt_active_o),
        .pin_mux_code_o(pin_mux_code_o), .pull_up_o(pull_up_o),
        .pull_down_o(pull_down_o), .analog_connect_o(analog_connect_o));

    periph_model i_far (.clk_i(clk_i), .rst_i(rst_i), .pad_o_i(pin_o),
        .pad_oe_i(pin_oe_o), .ext_i(ext_lvl), .pin_lvl_o(pin_i),
        .do_o(periph_do_i), .oe_o(periph_oe_i));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic end_sim();
        $display("errors %0d checks %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            $display("MISMATCH t=%0t run hung", $time);
            end_sim();
        end
    end

    task automatic chk(input logic [159:0] got, input logic [159:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wb_cycle(input logic w, input logic [2:0] port, input logic [3:0] idx,
                            input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= {port, idx, 2'b00};
        sel_i <= 4'hF;
        dat_i <= wd;
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask : wb_cycle

    task automatic wr(input logic [2:0] port, input logic [3:0] idx, input logic [31:0] wd);
        logic [31:0] dummy;
        wb_cycle(1'b1, port, idx, wd, dummy);
    endtask : wr

    task automatic rd_chk(input logic [2:0] port, input logic [3:0] idx, input logic [31:0] exp);
        logic [31:0] got;
        wb_cycle(1'b0, port, idx, 32'h0000_0000, got);
        chk(got, exp, "register read");
    endtask : rd_chk

    task automatic settle();
        repeat (2) @(negedge clk_i);
    endtask : settle

    task automatic do_reset();
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
    endtask : do_reset

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic test_defaults();
        chk(pin_oe_o, 40'h00_0000_0000, "pad drive at reset");
        chk(alt_active_o, 40'h00_000F_0C3F, "alt active");
        chk(pull_up_o, 40'h00_000F_0000, "pull up");
        chk(pull_down_o, 40'h00_0000_0000, "pull down");
        chk(pin_mux_code_o, {64'h0, 32'h0000_3333, 32'h0000_1100, 32'h0011_1111}, "codes");
        rd_chk(3'h0, pin_mux_pkg::REG_FUNC_CTL, 32'h0011_1111);
        rd_chk(3'h2, pin_mux_pkg::REG_ALT_SEL, 32'h0000_000F);
        rd_chk(3'h2, pin_mux_pkg::REG_LOCK, 32'h0000_0001);
        rd_chk(3'h3, pin_mux_pkg::REG_DIG_EN, 32'h0000_0000);
        settle();
        chk(pin_oe_o[39:20], 20'h00000, "plain pins tri-stated");
    endtask : test_defaults

    task automatic test_analog();
        chk(analog_connect_o, 40'h00_0000_5300, "direct analog only");
        wr(3'h3, pin_mux_pkg::REG_DIG_EN, 32'h0000_0008);
        wr(3'h3, pin_mux_pkg::REG_ANA_SEL, 32'h0000_000C);
        wr(3'h1, pin_mux_pkg::REG_DIG_EN, 32'h0000_001D);
        wr(3'h1, pin_mux_pkg::REG_ANA_SEL, 32'h0000_00FF);
        settle();
        chk(analog_connect_o[27:24], 4'h4, "isolated analog gating");
        chk(analog_connect_o[15:8], 8'h42, "direct analog gating");
        chk(analog_connect_o[7:0], 8'h00, "non analog pins");
    endtask : test_analog

    task automatic test_digital();
        logic prev;
        wr(3'h3, pin_mux_pkg::REG_ALT_SEL, 32'h0000_0001);
        wr(3'h3, pin_mux_pkg::REG_FUNC_CTL, 32'h0000_0002);
        settle();
        chk(alt_active_o[24], 1'b0, "alt needs digital enable");
        chk(pin_oe_o[24], 1'b0, "no drive without enable");
        wr(3'h3, pin_mux_pkg::REG_DIG_EN, 32'h0000_000D);
        wr(3'h3, pin_mux_pkg::REG_DIRECTION, 32'h0000_0004);
        wr(3'h3, pin_mux_pkg::REG_PORT_DATA, 32'h0000_0004);
        settle();
        chk(alt_active_o[31:24], 8'h01, "alt on one pin");
        chk(pin_mux_code_o[103:96], 8'h02, "code on one pin");
        wr(3'h0, pin_mux_pkg::REG_FUNC_CTL, 32'h0011_1112);
        wr(3'h2, pin_mux_pkg::REG_FUNC_CTL, 32'h5400_3333);
        settle();
        chk(pin_mux_code_o, {64'h0000_0000_0000_0002, 64'h5400_3333_0000_1100,
            32'h0011_1112}, "codes per pin");
        chk(pin_oe_o[24], 1'b1, "peripheral drive enable");
        for (int i = 0; i < 4; i++) begin
            @(negedge clk_i);
            prev = periph_do_i[24];
            @(negedge clk_i);
            chk(pin_o[24], prev, "peripheral value on pad");
            @(negedge clk_i);
            chk(periph_di_o[24], prev, "peripheral sees pad level");
        end
        chk({pin_oe_o[26], pin_o[26]}, 2'b11, "gpio output pin");
        chk(periph_di_o[26], 1'b0, "no peripheral input");
    endtask : test_digital

    task automatic test_lock();
        wr(3'h1, pin_mux_pkg::REG_ALT_SEL, 32'h0000_008C);
        rd_chk(3'h1, pin_mux_pkg::REG_ALT_SEL, 32'h0000_000C);
        wr(3'h2, pin_mux_pkg::REG_ALT_SEL, 32'h0000_0010);
        rd_chk(3'h2, pin_mux_pkg::REG_ALT_SEL, 32'h0000_001F);
        wr(3'h2, pin_mux_pkg::REG_COMMIT, 32'h0000_0001);
        wr(3'h2, pin_mux_pkg::REG_ALT_SEL, 32'h0000_0000);
        rd_chk(3'h2, pin_mux_pkg::REG_ALT_SEL, 32'h0000_000F);
        wr(3'h2, pin_mux_pkg::REG_LOCK, KEY);
        rd_chk(3'h2, pin_mux_pkg::REG_LOCK, 32'h0000_0000);
        wr(3'h2, pin_mux_pkg::REG_COMMIT, 32'h0000_0001);
        wr(3'h2, pin_mux_pkg::REG_ALT_SEL, 32'h0000_0000);
        wr(3'h2, pin_mux_pkg::REG_PULL_UP, 32'h0000_0000);
        wr(3'h2, pin_mux_pkg::REG_DIG_EN, 32'h0000_0000);
        settle();
        chk(alt_active_o[19:16], 4'hE, "committed pin only");
        chk(pull_up_o[19:16], 4'hE, "committed pull only");
        rd_chk(3'h5, pin_mux_pkg::REG_ALT_SEL, 32'h0000_0000);
        rd_chk(3'h0, 4'hA, 32'h0000_0000);
    endtask : test_lock

    initial begin
        do_reset();
        test_defaults();
        test_analog();
        test_digital();
        test_lock();
        do_reset();
        test_defaults();
        end_sim();
    end
endmodule : gpio_pin_function_mux_bench
`default_nettype wire
